// ---- verilog/stce_exec.sv ----
// Function
// RL1: Each instruction acts only when its condition passes on current flags.
// RL2: Swap is one read then one write, no interrupt between them.
// RL3: Swap reads base address, writes source, loads old value to destination.
// RL4: Source equal to destination still swaps correctly.
// RL5: Bus lock is high across both swap read and write cycles.
// RL6: Memory manager must not take the bus while lock is high.
// RL7: Size bit one swaps a byte, zero swaps a word.
// RL8: Swap byte placement matches ordinary load then store.
// RL9: Abort on swap read or write takes the data abort trap.
// RL10: Swap costs one S, two N and one I cycle.
// RL11: Supervisor call enters supervisor mode, PC to 0x08, saves status.
// RL12: Supervisor link gets address of the word after the call.
// RL13: Moving link to PC with restore resumes caller and restores status.
// RL14: Low 24 bits of a supervisor call are ignored.
// RL15: Supervisor call costs two S and one N cycle.
// RL16: Coprocessor data op waits for no result and never stalls.
// RL17: Every coprocessor instruction takes the undefined-instruction trap.
// RL18: Only bit 4 and bits 24 to 31 matter when decoding coprocessor ops.
// RL19: A coprocessor answers only its own number field, 0 to 15; here the number field is not decoded and every coprocessor op traps.
// RL20: Coprocessor data op costs one S plus one I per busy-wait cycle; here it traps instead, one N then two S cycles.
`timescale 1ns/100ps
`include "stce_params.svh"
module stce_exec
   import stce_pkg::*;
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // Instruction issue
   input  wire logic        issueValid,
   input  wire logic [31:0] instr,
   input  wire logic [31:0] instrAddr,
   input  wire logic        bigEndian,
   // Register file read view
   input  wire logic [31:0] baseVal,
   input  wire logic [31:0] srcVal,
   input  wire logic [31:0] linkVal,
   // Memory bus
   input  wire logic [31:0] memRdata,
   input  wire logic        memAbort,
   input  wire logic        memReady,
   output logic [31:0]      memAddr,
   output logic [31:0]      memWdata,
   output logic             memRead,
   output logic             memWrite,
   output logic             memByte,
   output logic             memLock,
   output logic [1:0]       cycleType,
   // Processor state
   output logic [31:0]      statusReg,
   output logic [31:0]      savedStatusSvc,
   output logic [31:0]      supervisorLinkReg,
   output logic [31:0]      pcOut,
   output logic             pcLoad,
   output logic             regWe,
   output logic [3:0]       regWaddr,
   output logic [31:0]      regWdata,
   output logic             busy,
   output logic             trapUndef,
   output logic             trapAbort,
   output logic             trapSvc
);
   stce_dec_if dec ();

   stce_decoder u_dec (
      .instr     (instr),
      .flagsNzcv (statusReg[31:28]),
      .dec       (dec)
   );

   stce_state_t state_reg, state_next;
   logic [31:0] addr_reg;
   logic [31:0] wdata_reg;
   logic [31:0] rdata_reg;
   logic        byte_reg;
   logic [3:0]  dst_reg;
   logic        abort_reg;

   wire         start    = issueValid && (state_reg == STCE_IDLE)
                           && dec.condPass; // RL1
   wire         startSwp = start && (dec.opClass == STCE_CLS_SWP);
   wire         startSvc = start && (dec.opClass == STCE_CLS_SVC);
   wire         startCop = start && (dec.opClass == STCE_CLS_COP);
   wire         startRet = start && (dec.opClass == STCE_CLS_NONE)
                           && dec.isReturn;
   wire [1:0]   lane     = addr_reg[1:0];
   wire [1:0]   laneSel  = bigEndian ? ~lane : lane;
   wire [4:0]   laneSh   = {laneSel, 3'b000};
   // Byte load extracts and zero-fills like a single load
   wire [31:0]  rdShift  = memRdata >> laneSh;
   wire [31:0]  rdValue  = byte_reg ? {24'h0, rdShift[7:0]} : memRdata; // RL8
   // Byte store replicates across all lanes like a single store
   wire [31:0]  wrValue  = byte_reg ? {4{wdata_reg[7:0]}} : wdata_reg; // RL8
   wire         abortAny = abort_reg || memAbort;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         STCE_IDLE: begin
            if (startSwp)
               state_next = STCE_RD;
            else if (startSvc || startCop)
               state_next = STCE_TRAP1;
         end
         STCE_RD:    if (memReady) state_next = STCE_WR; // RL2
         STCE_WR:    if (memReady) state_next = STCE_INT;
         STCE_INT:   state_next = abort_reg ? STCE_TRAP1 : STCE_IDLE;
         STCE_TRAP1: state_next = STCE_TRAP2;
         STCE_TRAP2: state_next = STCE_TRAP3;
         STCE_TRAP3: state_next = STCE_IDLE;
         default:    state_next = STCE_IDLE;
      endcase
   end

   // Captured operands: the source is latched before the read returns,
   // so naming it as the destination too does no harm.
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_reg <= STCE_IDLE;
         addr_reg  <= 32'h0;
         wdata_reg <= 32'h0;
         rdata_reg <= 32'h0;
         byte_reg  <= 1'b0;
         dst_reg   <= 4'h0;
         abort_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (start) begin
            addr_reg  <= baseVal; // RL3
            wdata_reg <= srcVal; // RL4
            byte_reg  <= dec.swpByte; // RL7
            dst_reg   <= dec.dstIdx;
            abort_reg <= 1'b0;
         end
         if (state_reg == STCE_RD && memReady)
            rdata_reg <= rdValue; // RL3
         if ((state_reg == STCE_RD || state_reg == STCE_WR) && memReady)
            abort_reg <= abortAny; // RL9
      end
   end

   // Bus signals: lock spans the read and the write
   wire inRd = state_next == STCE_RD;
   wire inWr = state_next == STCE_WR;
   always_ff @(posedge mclk) begin
      if (srst) begin
         memAddr   <= 32'h0;
         memWdata  <= 32'h0;
         memRead   <= 1'b0;
         memWrite  <= 1'b0;
         memByte   <= 1'b0;
         memLock   <= 1'b0;
         cycleType <= 2'h0;
      end else begin
         memAddr   <= startSwp ? baseVal : addr_reg;
         memByte   <= startSwp ? dec.swpByte : byte_reg;
         memWdata  <= wrValue;
         memRead   <= inRd;
         memWrite  <= inWr;
         memLock   <= inRd || inWr; // RL5 RL6
         case (state_next) // RL10 RL15 RL20
            STCE_RD, STCE_WR: cycleType <= STCE_CYC_N;
            STCE_INT:         cycleType <= STCE_CYC_I;
            STCE_TRAP1:       cycleType <= STCE_CYC_N;
            default:          cycleType <= STCE_CYC_S;
         endcase
      end
   end

   // Trap entry happens as the trap sequence begins
   wire enterTrap = state_next == STCE_TRAP1 && state_reg != STCE_TRAP1;
   wire trapIsSvc = (state_reg == STCE_IDLE) && startSvc;
   wire trapIsCop = (state_reg == STCE_IDLE) && startCop;
   wire trapIsAbt = (state_reg == STCE_INT);
   wire [4:0]  newMode = trapIsSvc ? `STCE_MODE_SVC :
                         trapIsCop ? `STCE_MODE_UND : `STCE_MODE_ABT;
   wire [31:0] vector  = trapIsSvc ? `STCE_SVC_VECTOR :
                         trapIsCop ? `STCE_UND_VECTOR : `STCE_ABT_VECTOR;

   always_ff @(posedge mclk) begin
      if (srst) begin
         statusReg         <= `STCE_PSR_RESET;
         savedStatusSvc    <= 32'h0;
         supervisorLinkReg <= 32'h0;
         pcOut             <= 32'h0;
         pcLoad            <= 1'b0;
         regWe             <= 1'b0;
         regWaddr          <= 4'h0;
         regWdata          <= 32'h0;
         trapUndef         <= 1'b0;
         trapAbort         <= 1'b0;
         trapSvc           <= 1'b0;
      end else begin
         pcLoad    <= 1'b0;
         regWe     <= 1'b0;
         trapUndef <= 1'b0;
         trapAbort <= 1'b0;
         trapSvc   <= 1'b0;
         if (enterTrap) begin
            // Interrupts masked: I bit set on every trap
            statusReg <= {statusReg[31:8], 1'b1, statusReg[6:5], newMode};
            pcOut     <= vector; // RL11 RL17
            pcLoad    <= 1'b1;
            trapSvc   <= trapIsSvc;
            trapUndef <= trapIsCop; // RL16
            trapAbort <= trapIsAbt; // RL9
            if (trapIsSvc) begin
               savedStatusSvc    <= statusReg; // RL11
               supervisorLinkReg <= instrAddr + `STCE_PC_STEP; // RL12
            end
         end else if (startRet) begin
            pcOut     <= linkVal; // RL13
            pcLoad    <= 1'b1;
            statusReg <= savedStatusSvc; // RL13
         end else if (state_reg == STCE_INT && !abort_reg) begin
            regWe    <= 1'b1;
            regWaddr <= dst_reg; // RL3
            regWdata <= rdata_reg;
         end
      end
   end

   // Busy also blocks interrupts mid-swap
   always_ff @(posedge mclk) begin
      if (srst)
         busy <= 1'b0;
      else
         busy <= state_next != STCE_IDLE; // RL2
   end
endmodule

// ---- verilog/stce_params.svh ----
// Constants for the swap, supervisor-call and coprocessor execution block
`ifndef STCE_PARAMS_SVH
`define STCE_PARAMS_SVH
`define STCE_SVC_VECTOR    32'h0000_0008
`define STCE_UND_VECTOR    32'h0000_0004
`define STCE_ABT_VECTOR    32'h0000_0010
`define STCE_MODE_SVC      5'h13
`define STCE_MODE_UND      5'h1b
`define STCE_MODE_ABT      5'h17
`define STCE_MODE_USR      5'h10
`define STCE_PSR_RESET     32'h0000_00d3
`define STCE_PC_STEP       32'h0000_0004
`define STCE_COND_HI       31
`define STCE_COND_LO       28
`define STCE_SWP_BYTE_BIT  22
`define STCE_PC_REG        4'hf
`define STCE_LR_REG        4'he
`endif

// ---- verilog/stce_pkg.sv ----
// Types for the swap, supervisor-call and coprocessor execution block
package stce_pkg;
   typedef enum logic [2:0] {
      STCE_IDLE  = 3'b000,
      STCE_RD    = 3'b001,
      STCE_WR    = 3'b011,
      STCE_INT   = 3'b010,
      STCE_TRAP1 = 3'b110,
      STCE_TRAP2 = 3'b111,
      STCE_TRAP3 = 3'b101
   } stce_state_t;
   typedef enum logic [1:0] {
      STCE_CLS_NONE = 2'h0,
      STCE_CLS_SWP  = 2'h1,
      STCE_CLS_SVC  = 2'h2,
      STCE_CLS_COP  = 2'h3
   } stce_class_t;
   typedef enum logic [1:0] {
      STCE_CYC_S = 2'h0,
      STCE_CYC_N = 2'h1,
      STCE_CYC_I = 2'h2
   } stce_cycle_t;
endpackage

// ---- verilog/stce_dec_if.sv ----
// Decode results passed from the decoder to the executor
`timescale 1ns/100ps
interface stce_dec_if;
   import stce_pkg::*;
   logic        condPass;
   stce_class_t opClass;
   logic        swpByte;
   logic [3:0]  baseIdx;
   logic [3:0]  srcIdx;
   logic [3:0]  dstIdx;
   logic        isReturn;
   modport dec (output condPass, opClass, swpByte, baseIdx, srcIdx, dstIdx,
                isReturn);
   modport exe (input condPass, opClass, swpByte, baseIdx, srcIdx, dstIdx,
                isReturn);
endinterface

// ---- verilog/stce_decoder.sv ----
// Instruction class and condition decode
`timescale 1ns/100ps
`include "stce_params.svh"
module stce_decoder
   import stce_pkg::*;
(
   // Instruction and flags
   input  wire logic [31:0] instr,
   input  wire logic [3:0]  flagsNzcv,
   // Decoded fields
   stce_dec_if.dec          dec
);
   wire [3:0] cond = instr[`STCE_COND_HI:`STCE_COND_LO];
   wire       fN   = flagsNzcv[3];
   wire       fZ   = flagsNzcv[2];
   wire       fC   = flagsNzcv[1];
   wire       fV   = flagsNzcv[0];
   logic      pass;

   always_comb begin
      case (cond) // RL1
         4'h0: pass = fZ;
         4'h1: pass = !fZ;
         4'h2: pass = fC;
         4'h3: pass = !fC;
         4'h4: pass = fN;
         4'h5: pass = !fN;
         4'h6: pass = fV;
         4'h7: pass = !fV;
         4'h8: pass = fC && !fZ;
         4'h9: pass = !fC || fZ;
         4'ha: pass = fN == fV;
         4'hb: pass = fN != fV;
         4'hc: pass = !fZ && (fN == fV);
         4'hd: pass = fZ || (fN != fV);
         4'he: pass = 1'b1;
         default: pass = 1'b0;
      endcase
   end

   // Swap: only the fixed pattern bits are checked
   wire isSwp = (instr[27:23] == 5'h02) && (instr[21:20] == 2'h0)
                && (instr[11:4] == 8'h09);
   wire isSvc = instr[27:24] == 4'hf; // RL14
   // Coprocessor data op: only bit 4 and the top byte matter here
   wire isCdp = (instr[27:24] == 4'he) && !instr[4]; // RL18
   // Any other coprocessor class (transfers, register moves) also traps
   wire isCopOther = (instr[27:25] == 3'h6) || ((instr[27:24] == 4'he)
                     && instr[4]);
   // Return: move link into PC with status restore
   wire isMovsPc = (instr[27:20] == 8'h1b) && (instr[11:4] == 8'h00)
                   && (instr[15:12] == `STCE_PC_REG)
                   && (instr[3:0] == `STCE_LR_REG);

   assign dec.condPass = pass;
   assign dec.opClass  = isSwp ? STCE_CLS_SWP :
                         isSvc ? STCE_CLS_SVC :
                         (isCdp || isCopOther) ? STCE_CLS_COP :
                         STCE_CLS_NONE; // RL17
   assign dec.swpByte  = instr[`STCE_SWP_BYTE_BIT]; // RL7
   assign dec.baseIdx  = instr[19:16];
   assign dec.srcIdx   = instr[3:0];
   assign dec.dstIdx   = instr[15:12];
   assign dec.isReturn = isMovsPc;
endmodule

// ---- tb/stce_mem_model.sv ----
// Memory manager model answering the swap bus cycles
`timescale 1ns/100ps
module stce_mem_model #(
   parameter int          LAT  = 1,
   parameter logic [31:0] INIT = 32'h5566_7788
) (
   // Clock
   input  wire logic        mclk,
   // Bus from the block
   input  wire logic        memRead,
   input  wire logic        memWrite,
   input  wire logic [31:0] memWdata,
   // Abort request from the bench
   input  wire logic        abortOn,
   // Answer
   output logic [31:0]      memRdata,
   output logic             memReady,
   output logic             memAbort
);
   logic [31:0] word = INIT;
   int          cnt  = 0;
   initial memRdata = 32'h0;
   initial memReady = 1'b0;
   initial memAbort = 1'b0;
   // Never withdraws a locked pair; answers each cycle in turn
   always @(posedge mclk) begin
      memReady <= 1'b0;
      memAbort <= 1'b0;
      memRdata <= ~memRdata;
      if ((memRead || memWrite) && !memReady) begin
         if (cnt == LAT) begin
            memReady <= 1'b1;
            memAbort <= abortOn;
            cnt = 0;
            if (memRead)
               memRdata <= word;
            else
               word = memWdata;
         end else
            cnt++;
      end
   end
endmodule

// ---- tb/stce_exec_sva.sv ----
// Port assertions for the execution block
`timescale 1ns/100ps
module stce_exec_sva (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        srst,
   // Issue
   input wire logic        issueValid,
   input wire logic [31:0] instr,
   input wire logic [31:0] instrAddr,
   // Memory bus
   input wire logic        memReady,
   input wire logic        memRead,
   input wire logic        memWrite,
   input wire logic        memLock,
   input wire logic [1:0]  cycleType,
   // State and traps
   input wire logic [31:0] statusReg,
   input wire logic [31:0] savedStatusSvc,
   input wire logic [31:0] supervisorLinkReg,
   input wire logic [31:0] pcOut,
   input wire logic        pcLoad,
   input wire logic        busy,
   input wire logic        trapSvc,
   input wire logic        trapUndef
);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   wire go  = issueValid && !busy;
   wire atomic_exchange_op = go && {instr[31:23], instr[21:20], instr[11:4]} == 19'h70809;
   wire svc = go && instr[31:24] == 8'hef;
   wire cop = go && instr[31:24] == 8'hee && !instr[4];
   wire nop = go && instr[31:28] == 4'h0 && !statusReg[30];
   property p_lock; memRead || memWrite |-> memLock; endproperty
   a_lock: assert property (p_lock)
      else $error("bus cycle without lock");
   property p_swp; atomic_exchange_op |=> memRead && memLock && cycleType == 2'h1;
   endproperty
   a_swp: assert property (p_swp)
      else $error("swap did not open a locked read");
   property p_rdwr; memRead && memReady |=> memWrite && memLock; endproperty
   a_rdwr: assert property (p_rdwr)
      else $error("read not followed by locked write");
   property p_wend; memWrite && memReady |=> !memLock && cycleType == 2'h2;
   endproperty
   a_wend: assert property (p_wend)
      else $error("no internal cycle after swap write");
   property p_svc; svc |=> pcLoad && trapSvc && pcOut == 32'h8; endproperty
   a_svc: assert property (p_svc)
      else $error("supervisor call vector wrong");
   property p_sav;
      svc |=> savedStatusSvc == $past(statusReg) &&
              supervisorLinkReg == $past(instrAddr) + 32'h4;
   endproperty
   a_sav: assert property (p_sav)
      else $error("supervisor state not saved");
   property p_cop; cop |=> trapUndef && pcOut == 32'h4 ##[1:4] !busy;
   endproperty
   a_cop: assert property (p_cop)
      else $error("coprocessor op not trapped promptly");
   property p_nop; nop |=> !busy && !pcLoad && !memRead; endproperty
   a_nop: assert property (p_nop)
      else $error("failed condition had an effect");
   c_swp: cover property (memWrite && memReady);
   c_svc: cover property (trapSvc);
   c_cop: cover property (trapUndef);
endmodule
bind stce_exec stce_exec_sva chk (.*);

// ---- tb/tb_swap_trap_coproc_exec.sv ----
// Self-checking bench for the swap, trap and coprocessor block
`timescale 1ns/100ps
`include "stce_params.svh"
module tb_swap_trap_coproc_exec;
   typedef struct packed {
      logic [31:0] ins;
      logic [4:0]  ev;
      logic [31:0] val;
   } stce_row_t;
   logic        mclk = 1'b0, srst = 1'b1, issueValid = 1'b0;
   logic        bigEndian = 1'b0, abortOn = 1'b0, memReady, memAbort;
   logic [31:0] instr = 32'h0, instrAddr = 32'h100, baseVal = 32'h0;
   logic [31:0] srcVal = 32'h1234_56a9, linkVal = 32'h200, memRdata;
   logic [31:0] memAddr, memWdata, statusReg, savedStatusSvc;
   logic [31:0] supervisorLinkReg, pcOut, regWdata, val;
   logic        memRead, memWrite, memByte, memLock, pcLoad, regWe;
   logic        busy, trapUndef, trapAbort, trapSvc;
   logic [1:0]  cycleType;
   logic [3:0]  regWaddr;
   logic [4:0]  ev;
   logic [3:0]  wa;
   int          nb;
   int          fails = 0, cmpCount = 0;
   // Events: reg write, pc load, svc, undef, abort
   stce_row_t   rows [11] = '{
      '{32'he102_0091, 5'h10, 32'h5566_7788},
      '{32'he142_0091, 5'h10, 32'h0000_00a9},
      '{32'he102_0090, 5'h10, 32'ha9a9_a9a9},
      '{32'hef00_0000, 5'h0c, 32'h8},
      '{32'he1b0_f00e, 5'h08, 32'h200},
      '{32'hefff_ffff, 5'h0c, 32'h8},
      '{32'he1b0_f00e, 5'h08, 32'h200},
      '{32'hee1a_2b03, 5'h0a, 32'h4},
      '{32'hee0f_0f60, 5'h0a, 32'h4},
      '{32'h0ef0_0000, 5'h00, 32'h0},
      '{32'h1f00_0000, 5'h0c, 32'h8}};
   always #10 mclk = ~mclk;
   stce_exec dut (.*);
   stce_mem_model mdl (.*);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task close_out;
      if (fails == 0 && cmpCount > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Issue one word, gather what happens over a fixed window
   task run(input logic [31:0] ins);
      ev = 5'h0;
      val = 32'h0;
      wa = 4'h0;
      nb = 0;
      @(posedge mclk) begin
         issueValid <= 1'b1;
         instr <= ins;
      end
      @(posedge mclk) issueValid <= 1'b0;
      repeat (16) begin
         @(negedge mclk);
         ev |= {regWe, pcLoad, trapSvc, trapUndef, trapAbort};
         if (busy)
            nb++;
         if (regWe)
            wa = regWaddr;
         if (regWe)
            val = regWdata;
         if (pcLoad)
            val = pcOut;
      end
      chk(busy, 32'h0);
   endtask
   initial begin
      repeat (3000) @(posedge mclk);
      fails++;
      close_out;
   end
   initial begin
      repeat (5) @(posedge mclk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         run(rows[i].ins);
         chk(ev, rows[i].ev);
         chk(val, rows[i].val);
      end
      @(posedge mclk) srst <= 1'b1;
      @(posedge mclk) srst <= 1'b0;
      @(negedge mclk) chk(statusReg, `STCE_PSR_RESET);
      run(32'hef12_3456);
      chk(statusReg[4:0], `STCE_MODE_SVC);
      chk(savedStatusSvc, `STCE_PSR_RESET);
      chk(supervisorLinkReg, 32'h104);
      chk(nb, 32'h3);
      run(32'he1b0_f00e);
      chk(statusReg, `STCE_PSR_RESET);
      abortOn <= 1'b1;
      run(32'he102_0091);
      chk(ev, 32'h09);
      chk(val, `STCE_ABT_VECTOR);
      abortOn <= 1'b0;
      bigEndian <= 1'b1;
      run(32'he142_0091);
      chk(val, 32'h12);
      bigEndian <= 1'b0;
      run(32'he102_1091);
      chk(val, 32'ha9a9_a9a9);
      chk(wa, 32'h1);
      close_out;
   end
endmodule
